//--- logic/phy_id_adv_pkg.sv
// Constants for the identifier and ability advertisement register bank
package phy_id_adv_pkg;
  // Register indices on the management port
  localparam logic [4:0] IDENT_HIGH_ADDR = 5'h02;
  localparam logic [4:0] IDENT_LOW_ADDR = 5'h03;
  localparam logic [4:0] ADVERT_ADDR = 5'h04;
  localparam logic [4:0] CONTROL_ADDR = 5'h19;
  // Advertisement register field positions
  localparam int NEXT_PAGE_POS = 15;
  localparam int ACK_RSVD_POS = 14;
  localparam int REMOTE_FAULT_POS = 13;
  localparam int RSVD12_POS = 12;
  localparam int ASYM_PAUSE_POS = 11;
  localparam int SYM_PAUSE_POS = 10;
  localparam int FOUR_PAIR_POS = 9;
  localparam int FAST_FD_POS = 8;
  localparam int FAST_HD_POS = 7;
  localparam int SLOW_FD_POS = 6;
  localparam int SLOW_HD_POS = 5;
  localparam int SELECTOR_LSB = 0;
  // Identifier layout in the low identifier register
  localparam int ORG_LOWER_LSB = 10;
  localparam int MODEL_LSB = 4;
  localparam int REV_LSB = 0;
  // Pause resolution field in the control register
  localparam int PAUSE_RX_POS = 13;
  localparam int PAUSE_TX_POS = 12;
  // Reset values
  localparam logic [4:0] SELECTOR_RESET = 5'h01;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // Identity values: arbitrary, not those of any real part
  localparam logic [15:0] ORG_UPPER_DEFAULT = 16'h1234;
  localparam logic [5:0] ORG_LOWER_DEFAULT = 6'h15;
  localparam logic [5:0] MODEL_DEFAULT = 6'h21;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1;
  // Strap sampler depth
  localparam int STRAP_SYNC_STAGES = 3;
endpackage

//--- logic/strap_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Raw and filtered levels
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] cleanOut
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  // Stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    stage1_ff <= rawIn;
    stage2_ff <= stage1_ff;
    stage3_ff <= stage2_ff;
  end

  // Output follows only stable agreement, so one glitchy sample never counts
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cleanOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_ff[i] == stage3_ff[i]) begin
          cleanOut[i] <= stage3_ff[i];
        end
      end
    end
  end
endmodule

//--- logic/phy_id_adv_regs.sv
// Identifier registers and ability advertisement register of the transceiver
//
// Function
// - The first identifier register shows organisation id bits 3..18.
// - The two top organisation id bits appear in neither register.
// - Low identifier bits 15..10 show organisation id bits 19..24.
// - Low identifier bits 9..4 show the model number, msb at bit 9.
// - Low identifier bits 3..0 show the revision, msb at bit 3.
// - The advertisement register holds the abilities sent to the partner.
// - Bit 15 is a writable next page request that resets to zero.
// - Bit 14 ignores writes and reads as zero.
// - Bit 13 is a writable remote fault advert that resets to zero.
// - Bit 12 is reserved, written as zero by software, read as zero.
// - Bit 11 is a writable asymmetric pause advert resetting to zero.
// - Bit 10 is a writable symmetric pause advert resetting to zero.
// - Control register bits 13:12 report the resolved pause directions.
// - Bit 9 reads as zero and ignores writes.
// - Bits 8..5 are writable abilities whose reset values come from straps.
// - Bits 4..0 are a writable selector that resets to 00001.
`timescale 1ns/1ps
module phy_id_adv_regs
  import phy_id_adv_pkg::*;
#(
  parameter logic [15:0] ORG_UPPER = phy_id_adv_pkg::ORG_UPPER_DEFAULT,
  parameter logic [5:0] ORG_LOWER = phy_id_adv_pkg::ORG_LOWER_DEFAULT,
  parameter logic [5:0] MODEL_NUM = phy_id_adv_pkg::MODEL_DEFAULT,
  parameter logic [3:0] MODEL_REV = phy_id_adv_pkg::REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Management register port from the serial management engine
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRvalid,
  // Strap pins: bit3 fast fd, bit2 fast, bit1 slow fd, bit0 slow
  input wire logic [3:0] abilityStrap,
  // Partner pause advertisement and link duplex from negotiation logic
  input wire logic partnerPause,
  input wire logic partnerAsymPause,
  input wire logic fullDuplex,
  // Local abilities to the negotiation engine
  output logic [15:0] advertWord,
  // Pause resolution
  output logic pauseRxEn,
  output logic pauseTxEn
);
  import phy_id_adv_pkg::*;

  logic [3:0] strapClean;
  logic strapLoad_ff;
  logic nextPage_ff;
  logic remoteFault_ff;
  logic asymPause_ff;
  logic symPause_ff;
  logic [3:0] ability_ff;
  logic [4:0] selector_ff;
  logic [15:0] identHigh;
  logic [15:0] identLow;
  logic [15:0] advertView;
  logic [15:0] controlView;
  logic [15:0] nxt_rdata;
  logic nxt_pauseRx;
  logic nxt_pauseTx;
  logic advertHit;

  // Straps are pins, so they pass the filtering synchroniser first
  strap_sync #(
    .WIDTH(4)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rawIn(abilityStrap),
    .cleanOut(strapClean)
  );

  // Fixed identity words; top two org id bits have no home
  assign identHigh = ORG_UPPER;
  assign identLow = {ORG_LOWER, MODEL_NUM, MODEL_REV};

  assign advertHit = regWrite && (regAddr == ADVERT_ADDR);

  // Strap capture runs a few cycles after reset release, once filtered
  logic [1:0] strapWait_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strapWait_ff <= 2'h0;
      strapLoad_ff <= 1'b0;
    end else begin
      if (strapWait_ff != 2'h3) begin
        strapWait_ff <= strapWait_ff + 2'h1;
      end
      strapLoad_ff <= (strapWait_ff == 2'h2);
    end
  end

  // Writable control bits of the advertisement register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      nextPage_ff <= 1'b0;
      remoteFault_ff <= 1'b0;
      asymPause_ff <= 1'b0;
      symPause_ff <= 1'b0;
      selector_ff <= SELECTOR_RESET;
    end else if (advertHit) begin
      nextPage_ff <= regWdata[NEXT_PAGE_POS];
      remoteFault_ff <= regWdata[REMOTE_FAULT_POS];
      asymPause_ff <= regWdata[ASYM_PAUSE_POS];
      symPause_ff <= regWdata[SYM_PAUSE_POS];
      selector_ff <= regWdata[SELECTOR_LSB +: 5];
    end
  end

  // Ability bits: strap value after reset, software may override later
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ability_ff <= 4'h0;
    end else if (advertHit) begin
      ability_ff <= regWdata[SLOW_HD_POS +: 4];
    end else if (strapLoad_ff) begin
      ability_ff <= strapClean;
    end
  end

  // Bits 14, 12 and 9 are tied low whatever was written
  always_comb begin
    advertView = READ_ZERO;
    advertView[NEXT_PAGE_POS] = nextPage_ff;
    advertView[ACK_RSVD_POS] = 1'b0;
    advertView[REMOTE_FAULT_POS] = remoteFault_ff;
    advertView[RSVD12_POS] = 1'b0;
    advertView[ASYM_PAUSE_POS] = asymPause_ff;
    advertView[SYM_PAUSE_POS] = symPause_ff;
    advertView[FOUR_PAIR_POS] = 1'b0;
    advertView[SLOW_HD_POS +: 4] = ability_ff;
    advertView[SELECTOR_LSB +: 5] = selector_ff;
  end

  // Standard pause resolution, only meaningful on full duplex links
  always_comb begin
    nxt_pauseRx = 1'b0;
    nxt_pauseTx = 1'b0;
    if (fullDuplex) begin
      if (symPause_ff && partnerPause) begin
        nxt_pauseRx = 1'b1;
        nxt_pauseTx = 1'b1;
      end else if (!symPause_ff && asymPause_ff && partnerPause &&
                   partnerAsymPause) begin
        nxt_pauseTx = 1'b1;
      end else if (symPause_ff && asymPause_ff && !partnerPause &&
                   partnerAsymPause) begin
        nxt_pauseRx = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pauseRxEn <= 1'b0;
      pauseTxEn <= 1'b0;
    end else begin
      pauseRxEn <= nxt_pauseRx;
      pauseTxEn <= nxt_pauseTx;
    end
  end

  // Control register view exposes only the pause field here
  always_comb begin
    controlView = READ_ZERO;
    controlView[PAUSE_RX_POS] = pauseRxEn;
    controlView[PAUSE_TX_POS] = pauseTxEn;
  end

  // Read mux; identifier reads never depend on writes
  always_comb begin
    case (regAddr)
      IDENT_HIGH_ADDR: nxt_rdata = identHigh;
      IDENT_LOW_ADDR: nxt_rdata = identLow;
      ADVERT_ADDR: nxt_rdata = advertView;
      CONTROL_ADDR: nxt_rdata = controlView;
      default: nxt_rdata = READ_ZERO;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata <= READ_ZERO;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= nxt_rdata;
      end
    end
  end

  // Abilities presented to the negotiation engine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      advertWord <= {11'h000, SELECTOR_RESET};
    end else begin
      advertWord <= advertView;
    end
  end

  // Identifier read returns the fixed high word
  a_ident_high_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == IDENT_HIGH_ADDR |=> regRdata == ORG_UPPER)
    else $error("identifier high read wrong");

  a_ident_low_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == IDENT_LOW_ADDR |=>
    regRdata == {ORG_LOWER, MODEL_NUM, MODEL_REV})
    else $error("identifier low read wrong");

  a_advert_zero_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == ADVERT_ADDR |=>
    regRdata[14] == 1'b0 && regRdata[12] == 1'b0 && regRdata[9] == 1'b0)
    else $error("reserved advert bit read nonzero");

  a_next_page_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> nextPage_ff == $past(regWdata[15]))
    else $error("next page write lost");

  a_fault_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> remoteFault_ff == $past(regWdata[13]))
    else $error("remote fault write lost");

  a_pause_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> asymPause_ff == $past(regWdata[11]) &&
    symPause_ff == $past(regWdata[10]))
    else $error("pause write lost");

  a_selector_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !advertHit |=> selector_ff == $past(selector_ff))
    else $error("selector changed without write");

  a_advert_publish: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> ##1 advertWord[4:0] == $past(regWdata[4:0], 2))
    else $error("advert word not published");

  a_pause_resolve: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fullDuplex && symPause_ff && partnerPause |=> pauseRxEn && pauseTxEn)
    else $error("symmetric pause not resolved");

  a_halfdup_nopause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fullDuplex |=> !pauseRxEn && !pauseTxEn)
    else $error("pause on half duplex");

  // Field-level identifier checks, so a swapped field is named directly
  a_ident_org_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == IDENT_LOW_ADDR |=> regRdata[15:10] == ORG_LOWER)
    else $error("org id lower field wrong");

  a_model_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == IDENT_LOW_ADDR |=> regRdata[9:4] == MODEL_NUM)
    else $error("model number field wrong");

  a_revision_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == IDENT_LOW_ADDR |=> regRdata[3:0] == MODEL_REV)
    else $error("revision field wrong");

  // A write to the high identifier followed by a read sees no change
  a_ident_write_ignored: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    regWrite && regAddr == IDENT_HIGH_ADDR ##1
    regRead && regAddr == IDENT_HIGH_ADDR |=> regRdata == ORG_UPPER)
    else $error("identifier changed by write");

  // Every read strobe is answered by exactly one valid pulse
  a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead |=> regRvalid)
    else $error("read not answered");

  a_no_stray_valid: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !regRead |=> !regRvalid)
    else $error("valid without read");

  // Published word never carries the tied-low bits
  a_published_zeros: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertWord[14] == 1'b0 && advertWord[12] == 1'b0 &&
    advertWord[9] == 1'b0)
    else $error("tied bit published as one");

  a_four_pair_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == ADVERT_ADDR |=> regRdata[9] == 1'b0)
    else $error("four pair bit read as one");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == ADVERT_ADDR |=> regRdata[12] == 1'b0)
    else $error("reserved bit read as one");

  // Ability bits: write wins, else strap load, else hold
  a_ability_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> ability_ff == $past(regWdata[8:5]))
    else $error("ability write lost");

  a_ability_strap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    strapLoad_ff && !advertHit |=> ability_ff == $past(strapClean))
    else $error("strap value not loaded");

  a_ability_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !advertHit && !strapLoad_ff |=> ability_ff == $past(ability_ff))
    else $error("ability changed unprompted");

  a_selector_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    advertHit |=> selector_ff == $past(regWdata[4:0]))
    else $error("selector write lost");

  // Single-bit controls keep their value between writes
  a_flags_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !advertHit |=> nextPage_ff == $past(nextPage_ff) &&
    remoteFault_ff == $past(remoteFault_ff))
    else $error("control flag changed unprompted");

  a_pause_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !advertHit |=> asymPause_ff == $past(asymPause_ff) &&
    symPause_ff == $past(symPause_ff))
    else $error("pause advert changed unprompted");

  a_advert_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == ADVERT_ADDR |=> regRdata == $past(advertView))
    else $error("advert read wrong");

  a_control_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRead && regAddr == CONTROL_ADDR |=>
    regRdata[13] == $past(pauseRxEn) && regRdata[12] == $past(pauseTxEn))
    else $error("pause field read wrong");

  // Asymmetric corners of the resolution table
  a_pause_asym_tx: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fullDuplex && !symPause_ff && asymPause_ff && partnerPause &&
    partnerAsymPause |=> !pauseRxEn && pauseTxEn)
    else $error("transmit-only pause not resolved");

  a_pause_asym_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fullDuplex && symPause_ff && asymPause_ff && !partnerPause &&
    partnerAsymPause |=> pauseRxEn && !pauseTxEn)
    else $error("receive-only pause not resolved");
endmodule

//--- tb/mgmt_ctrl_model.sv
// Management controller model that issues register reads and writes
`timescale 1ns/1ps
module mgmt_ctrl_model (
  // Clock
  input wire logic clk_sys,
  // Register port toward the bank
  output logic [4:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRvalid
);
  // Idle request lines from time zero
  initial begin
    regAddr = 5'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end

  // One-cycle write strobe; data goes stale once the strobe drops
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrite <= 1'b1;
    regWdata <= d & ~16'h1000; // Software keeps bit 12 at zero
    @(posedge clk_sys);
    regWrite <= 1'b0;
    regWdata <= ~d; // Released data must not look valid
  endtask

  // One-cycle read strobe, then a bounded wait for the valid pulse
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (regRvalid !== 1'b1 && n < 8);
    // A missing answer turns into unknowns so the compare fails
    d = (regRvalid === 1'b1) ? regRdata : 16'hXXXX;
  endtask
endmodule

//--- tb/phy_id_adv_regs_test.sv
// Self-checking bench for the identifier and advertisement register bank
`timescale 1ns/1ps
module phy_id_adv_regs_test;
  import phy_id_adv_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] regAddr;
  logic regWrite;
  logic regRead;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regRvalid;
  logic [3:0] abilityStrap = 4'h0;
  logic partnerPause = 1'b0;
  logic partnerAsymPause = 1'b0;
  logic fullDuplex = 1'b0;
  logic [15:0] advertWord;
  logic pauseRxEn;
  logic pauseTxEn;
  int n_errors = 0;
  int comparisons = 0;

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  phy_id_adv_regs u_phy_id_adv_regs (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata(regRdata), .regRvalid(regRvalid),
    .abilityStrap(abilityStrap), .partnerPause(partnerPause),
    .partnerAsymPause(partnerAsymPause), .fullDuplex(fullDuplex),
    .advertWord(advertWord), .pauseRxEn(pauseRxEn), .pauseTxEn(pauseTxEn)
  );

  mgmt_ctrl_model u_mgmt_ctrl_model (
    .clk_sys(clk_sys), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid)
  );

  // Resolved pause as {rx, tx}; half duplex never pauses
  function automatic logic [1:0] expPause(input logic ls, la, ps, pa, fd);
    if (!fd) return 2'b00;
    if (ls && ps) return 2'b11;
    if (ls && la && !ps && pa) return 2'b10;
    if (!ls && la && ps && pa) return 2'b01;
    return 2'b00;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d of %0d compares", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reset with fresh straps held stable well past the strap load
  task automatic do_reset();
    @(posedge clk_sys);
    abilityStrap <= 4'($urandom());
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
  endtask

  // Checks values left by reset, straps included
  task automatic check_reset();
    logic [15:0] d;
    u_mgmt_ctrl_model.rd(ADVERT_ADDR, d);
    check(d, {7'h00, abilityStrap, SELECTOR_RESET});
    check(advertWord, {7'h00, abilityStrap, SELECTOR_RESET});
  endtask

  initial begin
    logic [15:0] d;
    logic [15:0] w;
    logic [15:0] ea;
    logic [1:0] ep;
    d = 16'($urandom(32'hB8FD));
    do_reset();
    check_reset();
    // Identifiers read constant, before and after writing the inverse to the high one and a random word to the low one
    for (int k = 0; k < 2; k++) begin
      u_mgmt_ctrl_model.rd(IDENT_HIGH_ADDR, d);
      check(d, ORG_UPPER_DEFAULT);
      u_mgmt_ctrl_model.rd(IDENT_LOW_ADDR, d);
      check(d, {ORG_LOWER_DEFAULT, MODEL_DEFAULT, REVISION_DEFAULT});
      u_mgmt_ctrl_model.wr(IDENT_HIGH_ADDR, ~ORG_UPPER_DEFAULT);
      u_mgmt_ctrl_model.wr(IDENT_LOW_ADDR, 16'($urandom()));
    end
    // All ones and all zeros first, then random words and pause inputs
    for (int i = 0; i < 40; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom());
      u_mgmt_ctrl_model.wr(ADVERT_ADDR, w);
      ea = w & 16'hADFF; // Bits 14, 12 and 9 never hold a one
      u_mgmt_ctrl_model.rd(ADVERT_ADDR, d);
      check(d, ea);
      check(advertWord, ea);
      partnerPause <= 1'($urandom());
      partnerAsymPause <= 1'($urandom());
      fullDuplex <= 1'($urandom());
      repeat (2) @(posedge clk_sys);
      ep = expPause(ea[SYM_PAUSE_POS], ea[ASYM_PAUSE_POS], partnerPause,
                    partnerAsymPause, fullDuplex);
      u_mgmt_ctrl_model.rd(CONTROL_ADDR, d);
      check(d, {2'b00, ep, 12'h000});
      check({14'h0000, pauseRxEn, pauseTxEn}, {14'h0000, ep});
    end
    // Unmapped index reads as zero
    u_mgmt_ctrl_model.rd(5'h07, d);
    check(d, READ_ZERO);
    // A second reset discards every written bit
    do_reset();
    check_reset();
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end
endmodule
